// [design/btsc_pkg.sv]
// Package: opcodes, operand field positions, stack layout and cycle counts
package btsc_pkg;
    // First-byte opcodes
    localparam logic [7:0] OP_SKIP_CARRY = 8'hD7;
    localparam logic [7:0] OP_MEM_SET = 8'hF9;
    localparam logic [7:0] OP_MEM_CLR = 8'hF8;
    localparam logic [7:0] OP_TSTZ = 8'hFD;
    localparam logic [7:0] OP_XOR = 8'hF7;
    localparam logic [7:0] OP_CALL = 8'hDB;
    localparam logic [3:0] DIR_SET_LO = 4'h3;
    localparam logic [3:0] DIR_CLR_LO = 4'h2;
    localparam logic [1:0] DIR_HI = 2'h3;
    localparam logic [4:0] CALLS_HI = 5'h1D;
    localparam logic [1:0] CALL_B2_HI = 2'h1;
    // Second-byte operand classes (bits 7:6, or 7:4 for indexed)
    localparam logic [1:0] OPD_HNIB = 2'h0;
    localparam logic [1:0] OPD_IO_LO = 2'h2;
    localparam logic [1:0] OPD_IO_HI = 2'h3;
    localparam logic [3:0] OPD_IDX = 4'h4;
    localparam logic [3:0] IO_PAGE_LO = 4'hB;
    localparam logic [3:0] IO_PAGE_HI = 4'hF;
    localparam logic [3:0] IO_PAGE_TOP = 4'hF;
    localparam logic [3:0] BANK_ZERO = 4'h0;
    // Indexed operands always sit in the four top rows of the I/O page (FC0-FFF)
    localparam logic [1:0] IDX_ROW_HI = 2'h3;
    // Call arithmetic
    localparam logic [13:0] CALL_LEN = 14'h0003;
    localparam logic [13:0] CALLS_LEN = 14'h0002;
    localparam logic [7:0] STACK_DROP = 8'h06;
    localparam int CALL_CYCLES = 4;
    localparam int CALLS_CYCLES = 3;
    localparam logic [2:0] PUSH_LAST = 3'h5;
endpackage

// [design/btsc_exec.sv]
// Bit-test, skip, carry-xor and call execution unit
`timescale 1ns/1ps
// Behaviour
// (RULE1) Skip-if-set skips next when bit is one
// (RULE2) Carry form D7 skips when carry set
// (RULE3) Decode direct and F9 memory skip forms
// (RULE4) Test-set-clear skips on one, clears bit
// (RULE5) Test-set-clear uses first byte FD
// (RULE6) Carry xor bit, source left unchanged
// (RULE7) Carry xor decodes from first byte F7
// (RULE8) Indexed operand uses index register bits
// (RULE9) High-nibble operand: register plus low nibble
// (RULE10) High-nibble operand always hits bank zero
// (RULE11) I/O operand addresses FB0-FBF or FF0-FFF
// (RULE12) Long call: three bytes, four cycles; the code takes eight (decode, six pushes, jump)
// (RULE13) Long call pushes PC+3, flags, SP-6
// (RULE14) Flags, low PC, high PC stack slots
// (RULE15) Stacked nibble contents as laid out
// (RULE16) Short call: two bytes, three cycles; the code takes eight (decode, six pushes, jump)
// (RULE17) Short call pushes PC+2, clears upper PC
// (RULE18) Short-call targets lie in first 2K
// (RULE19) Skip-if-clear skips when bit is zero
// (RULE20) Skipped instruction fetched, effects suppressed
module btsc_exec
    import btsc_pkg::*;
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic INSTR_VALID,
    input wire logic [7:0] INSTR_B1,
    input wire logic [7:0] INSTR_B2,
    input wire logic [7:0] INSTR_B3,
    input wire logic [13:0] INSTR_PC,
    input wire logic [3:0] INDEX_REG,
    input wire logic [3:0] UPPER_NIBBLE_REG,
    input wire logic MEM_BANK_ENABLE_FLAG,
    input wire logic REG_BANK_ENABLE_FLAG,
    input wire logic [3:0] MEM_BANK_SEL,
    input wire logic [7:0] SP_IN,
    input wire logic CARRY_IN,
    input wire logic [3:0] MEM_RDATA,
    output logic BUSY,
    output logic SUPPRESS,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [11:0] MEM_ADDR,
    output logic [3:0] MEM_WDATA,
    output logic CARRY_WE,
    output logic CARRY_OUT,
    output logic SP_WE,
    output logic [7:0] SP_OUT,
    output logic PC_WE,
    output logic [13:0] PC_OUT,
    output logic DONE
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_READ = 5'b00010,
        ST_EXEC = 5'b00100,
        ST_PUSH = 5'b01000,
        ST_JUMP = 5'b10000
    } btsc_state_e;

    typedef enum logic [2:0] {
        K_SET = 3'h0,
        K_CLR = 3'h1,
        K_TSTZ = 3'h2,
        K_XOR = 3'h3,
        K_NONE = 3'h4
    } btsc_kind_e;

    btsc_state_e state_q;
    btsc_kind_e kind_q;
    logic [11:0] addr_q;
    logic [1:0] bit_q;
    logic [2:0] push_q;
    logic [7:0] sp_base_q;
    logic [23:0] frame_q;
    logic [13:0] target_q;
    logic skip_pend_q;
    logic busy_q, supp_q, rd_q, wr_q, cwe_q, cout_q, spwe_q, pcwe_q, done_q;
    logic [11:0] maddr_q;
    logic [3:0] wdata_q;
    logic [7:0] spout_q;
    logic [13:0] pcout_q;

    // Combinational decode of the presented instruction
    btsc_kind_e dec_kind;
    logic dec_mem, dec_carry_skip, dec_call, dec_calls;
    logic [11:0] dec_addr;
    logic [1:0] dec_bit;
    logic [3:0] dir_bank;

    always_comb
    begin
        dec_kind = K_NONE;
        dec_mem = 1'b0;
        dec_carry_skip = 1'b0;
        dec_call = 1'b0;
        dec_calls = 1'b0;
        dir_bank = MEM_BANK_ENABLE_FLAG ? MEM_BANK_SEL : BANK_ZERO;
        dec_addr = {dir_bank, INSTR_B2};
        dec_bit = INSTR_B1[5:4];
        if (INSTR_B1 == OP_SKIP_CARRY)
        begin
            dec_carry_skip = 1'b1; // RULE2
        end
        else if (INSTR_B1 == OP_CALL && INSTR_B2[7:6] == CALL_B2_HI)
        begin
            dec_call = 1'b1; // RULE12
        end
        else if (INSTR_B1[7:3] == CALLS_HI)
        begin
            dec_calls = 1'b1; // RULE16
        end
        else if (INSTR_B1[7:6] == DIR_HI && INSTR_B1[3:0] == DIR_SET_LO)
        begin
            dec_mem = 1'b1;
            dec_kind = K_SET; // RULE3
        end
        else if (INSTR_B1[7:6] == DIR_HI && INSTR_B1[3:0] == DIR_CLR_LO)
        begin
            dec_mem = 1'b1;
            dec_kind = K_CLR; // RULE19
        end
        else if (INSTR_B1 == OP_MEM_SET || INSTR_B1 == OP_MEM_CLR
                 || INSTR_B1 == OP_TSTZ || INSTR_B1 == OP_XOR)
        begin
            dec_mem = 1'b1;
            if (INSTR_B1 == OP_MEM_SET)
                dec_kind = K_SET; // RULE3
            else if (INSTR_B1 == OP_MEM_CLR)
                dec_kind = K_CLR; // RULE19
            else if (INSTR_B1 == OP_TSTZ)
                dec_kind = K_TSTZ; // RULE5
            else
                dec_kind = K_XOR; // RULE7
            dec_bit = INSTR_B2[5:4];
            // Second-byte operand selection
            if (INSTR_B2[7:4] == OPD_IDX)
            begin
                // Index picks one of four nibbles; bank flag has no say here
                dec_addr = {IO_PAGE_TOP, IDX_ROW_HI, INSTR_B2[3:0], INDEX_REG[3:2]}; // RULE8
                dec_bit = INDEX_REG[1:0]; // RULE8
            end
            else if (INSTR_B2[7:6] == OPD_HNIB)
            begin
                dec_addr = {BANK_ZERO, UPPER_NIBBLE_REG, INSTR_B2[3:0]}; // RULE9 RULE10
            end
            else if (INSTR_B2[7:6] == OPD_IO_LO)
            begin
                dec_addr = {IO_PAGE_TOP, IO_PAGE_LO, INSTR_B2[3:0]}; // RULE11
            end
            else if (INSTR_B2[7:6] == OPD_IO_HI)
            begin
                dec_addr = {IO_PAGE_TOP, IO_PAGE_HI, INSTR_B2[3:0]}; // RULE11
            end
            else
            begin
                dec_mem = 1'b0;
                dec_kind = K_NONE;
            end
        end
    end

    logic [13:0] ret_pc;
    assign ret_pc = INSTR_PC + (dec_call ? CALL_LEN : CALLS_LEN); // RULE13 RULE17

    // Main sequencer
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_q <= ST_IDLE;
            kind_q <= K_NONE;
            addr_q <= 12'h000;
            bit_q <= 2'h0;
            push_q <= 3'h0;
            sp_base_q <= 8'h00;
            frame_q <= 24'h000000;
            target_q <= 14'h0000;
            skip_pend_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (INSTR_VALID && skip_pend_q)
                    begin
                        skip_pend_q <= 1'b0; // RULE20
                    end
                    else if (INSTR_VALID && dec_mem)
                    begin
                        kind_q <= dec_kind;
                        addr_q <= dec_addr; // RULE8
                        bit_q <= dec_bit;
                        state_q <= ST_READ;
                    end
                    else if (INSTR_VALID && dec_carry_skip)
                    begin
                        skip_pend_q <= CARRY_IN; // RULE2
                    end
                    else if (INSTR_VALID && (dec_call || dec_calls))
                    begin
                        // Nibbles pushed SP-1 down to SP-6
                        frame_q <= {4'h0, 2'b00, MEM_BANK_ENABLE_FLAG, REG_BANK_ENABLE_FLAG,
                                    ret_pc[7:4], ret_pc[3:0], 1'b0, 1'b0,
                                    ret_pc[13:12], ret_pc[11:8]}; // RULE14 RULE15
                        target_q <= dec_call ? {INSTR_B2[5:0], INSTR_B3}
                                             : {3'b000, INSTR_B1[2:0], INSTR_B2}; // RULE12 RULE17
                        sp_base_q <= SP_IN;
                        push_q <= 3'h0;
                        state_q <= ST_PUSH;
                    end
                end
                ST_READ:
                begin
                    state_q <= ST_EXEC;
                end
                ST_EXEC:
                begin
                    if (kind_q == K_CLR)
                        skip_pend_q <= ~MEM_RDATA[bit_q]; // RULE19
                    else if (kind_q != K_XOR)
                        skip_pend_q <= MEM_RDATA[bit_q]; // RULE1 RULE4
                    state_q <= ST_IDLE;
                end
                ST_PUSH:
                begin
                    frame_q <= {frame_q[19:0], 4'h0};
                    push_q <= push_q + 3'h1;
                    if (push_q == PUSH_LAST)
                        state_q <= ST_JUMP;
                end
                ST_JUMP:
                begin
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Registered outputs towards memory, carry, stack pointer and PC
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            busy_q <= 1'b0;
            supp_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            maddr_q <= 12'h000;
            wdata_q <= 4'h0;
            cwe_q <= 1'b0;
            cout_q <= 1'b0;
            spwe_q <= 1'b0;
            spout_q <= 8'h00;
            pcwe_q <= 1'b0;
            pcout_q <= 14'h0000;
            done_q <= 1'b0;
        end
        else
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cwe_q <= 1'b0;
            spwe_q <= 1'b0;
            pcwe_q <= 1'b0;
            // Carry test ends in its decode cycle, so it reports done at once
            done_q <= (state_q == ST_IDLE) && INSTR_VALID && !skip_pend_q
                      && dec_carry_skip; // RULE2
            // Skipped instruction still fetched, its effects are masked
            supp_q <= (state_q == ST_IDLE) && INSTR_VALID && skip_pend_q; // RULE20
            busy_q <= (state_q != ST_IDLE)
                      || (INSTR_VALID && !skip_pend_q && (dec_mem || dec_call || dec_calls));
            case (state_q)
                ST_READ:
                begin
                    rd_q <= 1'b1;
                    maddr_q <= addr_q;
                end
                ST_EXEC:
                begin
                    done_q <= 1'b1;
                    if (kind_q == K_XOR)
                    begin
                        cwe_q <= 1'b1;
                        cout_q <= CARRY_IN ^ MEM_RDATA[bit_q]; // RULE6
                    end
                    else if (kind_q == K_TSTZ)
                    begin
                        wr_q <= 1'b1;
                        wdata_q <= MEM_RDATA & ~(4'h1 << bit_q); // RULE4
                    end
                end
                ST_PUSH:
                begin
                    wr_q <= 1'b1;
                    maddr_q <= {MEM_BANK_SEL & {4{MEM_BANK_ENABLE_FLAG}},
                                sp_base_q - {5'h00, push_q} - 8'h01}; // RULE14
                    wdata_q <= frame_q[23:20]; // RULE15
                end
                ST_JUMP:
                begin
                    spwe_q <= 1'b1;
                    spout_q <= sp_base_q - STACK_DROP; // RULE13 RULE17
                    pcwe_q <= 1'b1;
                    pcout_q <= target_q; // RULE12 RULE17
                    done_q <= 1'b1;
                end
                default:
                begin
                end
            endcase
        end
    end

    assign BUSY = busy_q;
    assign SUPPRESS = supp_q;
    assign MEM_RD = rd_q;
    assign MEM_WR = wr_q;
    assign MEM_ADDR = maddr_q;
    assign MEM_WDATA = wdata_q;
    assign CARRY_WE = cwe_q;
    assign CARRY_OUT = cout_q;
    assign SP_WE = spwe_q;
    assign SP_OUT = spout_q;
    assign PC_WE = pcwe_q;
    assign PC_OUT = pcout_q;
    assign DONE = done_q;

    // Checks
    a_xor_carry: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE6
        (state_q == ST_EXEC && kind_q == K_XOR) |=> CARRY_WE && !MEM_WR)
        else $error("carry xor did not write carry");
    a_tstz_clear: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE4
        (state_q == ST_EXEC && kind_q == K_TSTZ) |=> MEM_WR && MEM_WDATA[$past(bit_q)] == 1'b0)
        else $error("test-set-clear left bit set");
    a_test_nowrite: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE1
        (state_q == ST_EXEC && (kind_q == K_SET || kind_q == K_CLR)) |=> !MEM_WR)
        else $error("bit test wrote memory");
    a_set_skip: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE1
        (state_q == ST_EXEC && kind_q == K_SET) |=> skip_pend_q == $past(MEM_RDATA[bit_q]))
        else $error("skip-if-set wrong");
    a_clr_skip: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE19
        (state_q == ST_EXEC && kind_q == K_CLR) |=> skip_pend_q != $past(MEM_RDATA[bit_q]))
        else $error("skip-if-clear wrong");
    a_carry_skip: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE2
        (state_q == ST_IDLE && INSTR_VALID && !skip_pend_q && dec_carry_skip)
        |=> skip_pend_q == $past(CARRY_IN))
        else $error("carry skip wrong");
    a_hnib_bank0: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE10
        (state_q == ST_IDLE && INSTR_VALID && !skip_pend_q && dec_mem
         && INSTR_B1[7:6] == DIR_HI && INSTR_B1[3:0] != DIR_SET_LO
         && INSTR_B1[3:0] != DIR_CLR_LO && INSTR_B2[7:6] == OPD_HNIB)
        |=> addr_q[11:8] == BANK_ZERO)
        else $error("high-nibble operand left bank 0");
    a_call_pushes: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE13
        (state_q == ST_IDLE && $past(state_q) == ST_JUMP) |-> SP_WE
        && SP_OUT == $past(sp_base_q) - STACK_DROP)
        else $error("call stack pointer not lowered by six");
    a_push_count: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE14
        (state_q == ST_PUSH && push_q == 3'h0) |-> (state_q == ST_PUSH) [*6] ##1 state_q == ST_JUMP)
        else $error("call did not push six nibbles");
    a_suppress: assert property (@(posedge MCLK) disable iff (!ARST_N) // RULE20
        (state_q == ST_IDLE && INSTR_VALID && skip_pend_q) |=> SUPPRESS && !BUSY)
        else $error("skipped instruction not suppressed");
    c_skip_taken: cover property (@(posedge MCLK) disable iff (!ARST_N) SUPPRESS);
    c_xor_done: cover property (@(posedge MCLK) disable iff (!ARST_N) CARRY_WE);
    c_call_done: cover property (@(posedge MCLK) disable iff (!ARST_N) PC_WE);
endmodule

// [verif/btsc_dmem_model.sv]
// Nibble-wide data memory model on the far side of the execution unit
`timescale 1ns/1ps
module btsc_dmem_model
(
    input wire logic clk,
    input wire logic rd,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [3:0] wdata,
    output logic [3:0] rdata
);
    logic [3:0] mem [4096];
    logic [3:0] last_q;
    logic hold_q;
    // Preset contents so every bit position reads as both one and zero
    initial
    begin
        last_q = 4'h0;
        hold_q = 1'b0;
        for (int a = 0; a < 4096; a++)
            mem[a] = 4'(a ^ (a >> 4) ^ (a >> 8));
    end
    // Read data lasts the read cycle and one more, then churns so stale data is caught
    always @(posedge clk)
    begin
        hold_q <= rd;
        if (rd)
            last_q <= mem[addr];
        else if (!hold_q)
            last_q <= ~last_q;
        if (wr)
            mem[addr] <= wdata;
    end
    assign rdata = rd ? mem[addr] : (hold_q ? last_q : ~last_q);
endmodule

// [verif/tb_top.sv]
// Self-checking bench: directed and random instructions against a queue-based model
`timescale 1ns/1ps
module tb_top;
    import btsc_pkg::*;
    logic MCLK = 0, ARST_N = 0, INSTR_VALID = 0, CARRY_IN = 0;
    logic MEM_BANK_ENABLE_FLAG = 0, REG_BANK_ENABLE_FLAG = 0;
    logic [7:0] INSTR_B1 = '0, INSTR_B2 = '0, INSTR_B3 = '0, SP_IN = '0;
    logic [13:0] INSTR_PC = '0;
    logic [3:0] INDEX_REG = '0, UPPER_NIBBLE_REG = '0, MEM_BANK_SEL = '0;
    wire logic [3:0] MEM_RDATA;
    logic BUSY, SUPPRESS, MEM_RD, MEM_WR, CARRY_WE, CARRY_OUT, SP_WE, PC_WE, DONE;
    logic [11:0] MEM_ADDR;
    logic [3:0] MEM_WDATA;
    logic [7:0] SP_OUT;
    logic [13:0] PC_OUT;
    int n_mismatch = 0, compares = 0, seed = 32'h6ef8;
    logic [3:0] bm [4096];
    logic [15:0] wq [$];
    logic [3:0] l, h, sel;
    logic memory_bank_enable_flag, register_bank_enable_flag, carry, pend;
    logic [7:0] sp, b1, b2;
    logic [13:0] pc;
    logic [31:0] t;
    logic [7:0] mops [4] = '{OP_XOR, OP_MEM_SET, OP_MEM_CLR, OP_TSTZ};

    btsc_exec dut (.MCLK(MCLK), .ARST_N(ARST_N), .INSTR_VALID(INSTR_VALID),
        .INSTR_B1(INSTR_B1), .INSTR_B2(INSTR_B2), .INSTR_B3(INSTR_B3), .INSTR_PC(INSTR_PC),
        .INDEX_REG(INDEX_REG), .UPPER_NIBBLE_REG(UPPER_NIBBLE_REG),
        .MEM_BANK_ENABLE_FLAG(MEM_BANK_ENABLE_FLAG), .REG_BANK_ENABLE_FLAG(REG_BANK_ENABLE_FLAG),
        .MEM_BANK_SEL(MEM_BANK_SEL), .SP_IN(SP_IN), .CARRY_IN(CARRY_IN), .MEM_RDATA(MEM_RDATA),
        .BUSY(BUSY), .SUPPRESS(SUPPRESS), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .CARRY_WE(CARRY_WE), .CARRY_OUT(CARRY_OUT), .SP_WE(SP_WE),
        .SP_OUT(SP_OUT), .PC_WE(PC_WE), .PC_OUT(PC_OUT), .DONE(DONE));
    btsc_dmem_model mem_model (.clk(MCLK), .rd(MEM_RD), .wr(MEM_WR), .addr(MEM_ADDR),
        .wdata(MEM_WDATA), .rdata(MEM_RDATA));

    // Free-running core clock
    initial
        forever #12.5 MCLK = ~MCLK;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Drive one instruction, predict its effects, then match every pulse it makes
    task automatic issue(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
        logic [11:0] a;
        logic [1:0] bi;
        logic [13:0] r, epc;
        logic [23:0] d;
        logic [3:0] bk;
        logic sup, skip, bv, xrd, xcw, xpc, fin, s;
        {sup, pend, skip, xrd, xcw, xpc, fin, s} = {pend, 7'h00};
        @(posedge MCLK);
        {INSTR_VALID, INSTR_B1, INSTR_B2, INSTR_B3, INSTR_PC} <= {1'b1, c1, c2, c3, pc};
        {INDEX_REG, UPPER_NIBBLE_REG, MEM_BANK_SEL} <= {l, h, sel};
        {MEM_BANK_ENABLE_FLAG, REG_BANK_ENABLE_FLAG, SP_IN, CARRY_IN} <= {memory_bank_enable_flag, register_bank_enable_flag, sp, carry};
        bk = memory_bank_enable_flag ? sel : 4'h0;
        if (c1[7:6] == 2'b11 && c1[3:1] == 3'b001)
            {a, bi} = {bk, c2, c1[5:4]};
        else if (c2[7])
            {a, bi} = {4'hF, (c2[6] ? 4'hF : 4'hB), c2[3:0], c2[5:4]};
        else if (c2[6])
            {a, bi} = {4'hF, 2'b11, c2[3:0], l};
        else
            {a, bi} = {4'h0, h, c2[3:0], c2[5:4]};
        bv = bm[a][bi];
        r = pc + ((c1 == OP_CALL) ? 14'h0003 : 14'h0002);
        d = {4'h0, 2'b00, memory_bank_enable_flag, register_bank_enable_flag, r[7:4], r[3:0], 2'b00, r[13:12], r[11:8]};
        // A skipped instruction changes nothing in the model
        if (!sup)
            case (c1)
                OP_SKIP_CARRY: skip = carry;
                OP_XOR: {xrd, xcw, carry} = {2'b11, carry ^ bv};
                OP_MEM_CLR: {xrd, skip} = {1'b1, !bv};
                OP_MEM_SET: {xrd, skip} = {1'b1, bv};
                OP_TSTZ:
                begin
                    {xrd, skip} = {1'b1, bv};
                    bm[a][bi] = 1'b0;
                    wq.push_back({a, bm[a]});
                end
                default:
                    if (c1[7:6] == 2'b11 && c1[3:1] == 3'b001)
                        {xrd, skip} = {1'b1, c1[0] ? bv : !bv};
                    else
                    begin
                        xpc = 1;
                        epc = (c1 == OP_CALL) ? {c2[5:0], c3} : {3'h0, c1[2:0], c2};
                        for (int k = 1; k <= 6; k++)
                        begin
                            a = {bk, sp - 8'(k)};
                            bm[a] = d[27 - 4 * k -: 4];
                            wq.push_back({a, bm[a]});
                        end
                        sp = sp - 8'h06;
                    end
            endcase
        @(posedge MCLK);
        INSTR_VALID <= 0;
        for (int i = 0; i < 16 && !fin; i++)
        begin
            #1;
            // Busy only for work that runs past its decode cycle
            if (i == 0)
                chk(BUSY, xrd | xpc);
            if (SUPPRESS === 1'b1)
                {s, fin} = 2'b11;
            if (MEM_RD === 1'b1)
            begin
                chk({xrd, MEM_ADDR}, {1'b1, a});
                xrd = 0;
            end
            if (MEM_WR === 1'b1 && wq.size() == 0)
                chk(MEM_WR, 1'b0);
            else if (MEM_WR === 1'b1)
                chk({MEM_ADDR, MEM_WDATA}, wq.pop_front());
            if (CARRY_WE === 1'b1)
            begin
                chk({xcw, CARRY_OUT}, {1'b1, carry});
                xcw = 0;
            end
            if (PC_WE === 1'b1)
            begin
                chk({xpc, SP_WE, SP_OUT, PC_OUT}, {2'b11, sp, epc});
                {xpc, fin} = 2'b01;
            end
            if (DONE === 1'b1)
                fin = 1;
            @(posedge MCLK);
        end
        if (!fin)
        begin
            n_mismatch++;
            $display("BAD t=%0t timeout got=%h exp=%h", $time, fin, 1'b1);
            finish_test();
        end
        chk({s, xrd, xcw, xpc, wq.size() == 0}, {sup, 4'b0001});
        wq.delete();
        pend = skip;
    endtask

    // Reset, directed corner cases, then a long random stream
    initial
    begin
        for (int a = 0; a < 4096; a++)
            bm[a] = 4'(a ^ (a >> 4) ^ (a >> 8));
        {l, h, sel, memory_bank_enable_flag, register_bank_enable_flag, carry, pend, sp, pc} = '0;
        repeat (16) @(posedge MCLK);
        chk({BUSY, DONE, PC_WE, MEM_WR, MEM_RD}, 5'h00);
        ARST_N <= 1;
        {pc, register_bank_enable_flag} = {14'h0123, 1'b1};
        issue(OP_CALL, 8'h4E, 8'h3F);
        {pc, sp, memory_bank_enable_flag, sel} = {14'h3FFE, 8'h02, 1'b1, 4'h5};
        issue(8'hEF, 8'hFF, 8'h00);
        l = 4'h9;
        issue(OP_MEM_SET, 8'h4F, 8'h00);
        carry = 1;
        issue(OP_SKIP_CARRY, 8'h00, 8'h00);
        issue(OP_XOR, 8'hC1, 8'h00);
        $display("directed test done");
        for (int n = 0; n < 600; n++)
        begin
            t = $random(seed);
            {l, h, sel, memory_bank_enable_flag, register_bank_enable_flag} = 14'($random(seed));
            {pc, sp} = 22'($random(seed));
            if (t[24])
                carry = t[25];
            b2 = t[22] ? {1'b1, t[6:0]} : (t[23] ? {4'h4, t[3:0]} : {2'b00, t[5:0]});
            case (t[18:16])
                3'h0: {b1, b2} = {2'b11, t[20:19], 3'b001, t[21], t[7:0]};
                3'h5: b1 = OP_SKIP_CARRY;
                3'h6: {b1, b2} = {OP_CALL, CALL_B2_HI, t[5:0]};
                3'h7: {b1, b2} = {CALLS_HI, t[21:19], t[7:0]};
                default: b1 = mops[t[17:16]];
            endcase
            issue(b1, b2, t[15:8]);
        end
        $display("random test done");
        finish_test();
    end
endmodule
